// [common/mmf_params.svh]
// mmf_params.svh: offsets, field positions, reset values of the fault block
// assumes: included by the core, the checker and the bench after the package
`ifndef MMF_PARAMS_SVH
`define MMF_PARAMS_SVH

`define MMF_STATUS_ADDR 32'hE000ED28
`define MMF_ADDRESS_ADDR 32'hE000ED34
`define MMF_CTRL_ADDR 32'hE000ED94
`define MMF_STATUS_NS_ADDR 32'hE002ED28
`define MMF_ADDRESS_NS_ADDR 32'hE002ED34
`define MMF_CTRL_NS_ADDR 32'hE002ED94

`define MMF_BIT_IACC 0
`define MMF_BIT_DACC 1
`define MMF_BIT_UNSTK 3
`define MMF_BIT_STK 4
`define MMF_BIT_LSP 5
`define MMF_BIT_AVALID 7
`define MMF_STATUS_IMPL 8'hBB

`define MMF_CTRL_ENABLE 0
`define MMF_CTRL_NEGPRI 1
`define MMF_CTRL_PRIVDEF 2

`define MMF_STATUS_RST 8'h00
`define MMF_CTRL_RST 3'h0
`define MMF_ADDR_RST 32'h00000000

`define MMF_RSYNC_STAGES 2

`endif

// [common/mmf_pkg.sv]
// mmf_pkg: types of the fault status and attribute block
// assumes: nothing beyond the standard language
package mmf_pkg;

  typedef enum logic [1:0] {
    MMF_SZ_BYTE,
    MMF_SZ_HALF,
    MMF_SZ_WORD
  } mmf_size_e;

  typedef enum logic [2:0] {
    MMF_MEM_DEVICE,
    MMF_MEM_NONCACHE,
    MMF_MEM_WT_TRANS,
    MMF_MEM_WB_TRANS,
    MMF_MEM_WT_NONTRANS,
    MMF_MEM_WB_NONTRANS,
    MMF_MEM_BAD
  } mmf_memtype_e;

  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    mmf_size_e size;
    logic priv;
    logic secure;
    logic debug;
  } mmf_bus_s;

  typedef struct packed {
    logic valid;
    logic secure;
    logic lazy_fp;
    logic entry_stack;
    logic return_unstack;
    logic data_viol;
    logic instr_viol;
    logic instr_exec;
    logic [31:0] addr;
    logic bus_addr_valid;
  } mmf_fault_s;

  typedef struct packed {
    logic [3:0] outer;
    logic [3:0] inner;
  } mmf_attr_s;

  typedef struct packed {
    mmf_memtype_e outer_type;
    mmf_memtype_e inner_type;
    logic [1:0] device_kind;
    logic outer_ra;
    logic outer_wa;
    logic inner_ra;
    logic inner_wa;
    logic legal;
  } mmf_attr_dec_s;

  typedef struct packed {
    logic [7:0] status_s;
    logic [7:0] status_ns;
    logic [31:0] addr_s;
    logic [31:0] addr_ns;
    logic [2:0] ctrl_s;
    logic [2:0] ctrl_ns;
    logic [31:0] rdata;
    logic rvalid;
    logic bus_err;
    mmf_attr_dec_s attr;
  } mmf_state_s;

endpackage

// [core/mmf_core.sv]
// mmf_core: fault status byte, fault address register, protection control
// assumes: core access path gives one-cycle fault pulses and register requests
`timescale 1ns/1ps
`include "mmf_params.svh"
// Operation
// (RQ1) fault captures 32-bit address at fixed location
// (RQ2) address meaningful only while valid flag set
// (RQ3) shared register unspecified when bus-fault valid
// (RQ4) bit 7 marks captured address valid
// (RQ5) bit 5 set on lazy FP fault
// (RQ6) bit 4 set on entry stacking fault
// (RQ7) bit 3 set on return unstacking fault
// (RQ8) data violation sets bit 1, captures address
// (RQ9) instruction violation recorded only when executed
// (RQ10) status byte write-one-to-clear, bits 6,2 zero
// (RQ11) all status flags clear on warm reset
// (RQ12) privileged access only, unprivileged raises fault
// (RQ13) status byte narrow access needs main extension
// (RQ14) status banked, alias zero to nonsecure/debug
// (RQ15) address banked, nonsecure alias for secure
// (RQ16) attribute upper field selects memory type
// (RQ17) low bits carry allocate hints, 00 transient excluded
// (RQ18) device kind in bits 3:2, 1:0 zero
// (RQ19) inner field uses normal encodings, 0000 bad
// (RQ20) control writable unless locked, word only
// (RQ21) control banked, alias zero to nonsecure
// (RQ22) bit 0 enables protection unit
// (RQ23) bit 2 background map, ignored when disabled; core passes it out as stored
// (RQ24) bit 1 negative priority use, needs enable; core passes it out as stored
// (RQ25) write one clears, fault in same cycle wins
module mmf_core
  import mmf_pkg::*;
#(
  parameter bit MAIN_EXT = 1'b1,
  parameter bit CTRL_WRITABLE = 1'b1,
  parameter bit SHARED_FAULT_ADDR = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire mmf_bus_s bus_in,
  input wire mmf_fault_s fault_in,
  input wire mmf_attr_s attr_in,
  output logic [31:0] rdata,
  output logic rvalid,
  output logic bus_err,
  output logic [2:0] ctrl_secure,
  output logic [2:0] ctrl_nonsecure,
  output logic [7:0] status_secure,
  output logic [7:0] status_nonsecure,
  output mmf_attr_dec_s attr_dec
);

  mmf_state_s st_ff;
  mmf_state_s nxt_st;
  logic [1:0] rst_sync_ff;
  logic rst_int_n;

  // ----------------------------------------------------------------
  // attribute decode
  // ----------------------------------------------------------------
  // (RQ16) normal field type
  function automatic mmf_memtype_e mmf_normal_type(input logic [3:0] f);
    mmf_memtype_e t;
    t = MMF_MEM_BAD;
    unique case (f[3:2])
      2'h0: t = (f[1:0] == 2'h0) ? MMF_MEM_DEVICE : MMF_MEM_WT_TRANS;
      2'h1: t = (f[1:0] == 2'h0) ? MMF_MEM_NONCACHE : MMF_MEM_WB_TRANS;
      2'h2: t = MMF_MEM_WT_NONTRANS;
      2'h3: t = MMF_MEM_WB_NONTRANS;
    endcase
    return t;
  endfunction

  function automatic mmf_attr_dec_s mmf_attr_decode(input mmf_attr_s a);
    mmf_attr_dec_s d;
    d = '0;
    d.outer_type = mmf_normal_type(a.outer);
    if (a.outer == 4'h0) begin
      // (RQ18) device kind bits
      d.device_kind = a.inner[3:2];
      d.inner_type = MMF_MEM_DEVICE;
      d.legal = (a.inner[1:0] == 2'h0);
    end else begin
      // (RQ19) inner normal encoding
      d.inner_type = (a.inner == 4'h0) ? MMF_MEM_BAD : mmf_normal_type(a.inner);
      // (RQ17) allocate hints
      d.outer_ra = (a.outer[3:2] != 2'h1 || a.outer[1:0] != 2'h0) & a.outer[1];
      d.outer_wa = (a.outer[3:2] != 2'h1 || a.outer[1:0] != 2'h0) & a.outer[0];
      d.inner_ra = (a.inner[3:2] != 2'h1 || a.inner[1:0] != 2'h0) & a.inner[1];
      d.inner_wa = (a.inner[3:2] != 2'h1 || a.inner[1:0] != 2'h0) & a.inner[0];
      d.legal = (a.inner != 4'h0);
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic mmf_hit(input logic [31:0] a, input logic [31:0] sec_addr,
    input logic [31:0] ns_addr);
    return (a == sec_addr) || (a == ns_addr);
  endfunction

  // (RQ25) set wins over clear
  function automatic logic [7:0] mmf_w1c(input logic [7:0] cur, input logic [7:0] clr,
    input logic [7:0] setv);
    return (cur & ~clr) | setv;
  endfunction

  function automatic logic [7:0] mmf_fault_flags(input mmf_fault_s f);
    logic [7:0] v;
    v = 8'h00;
    if (f.valid) begin
      // (RQ5) (RQ6) (RQ7) fault kinds
      v[`MMF_BIT_LSP] = f.lazy_fp;
      v[`MMF_BIT_STK] = f.entry_stack;
      v[`MMF_BIT_UNSTK] = f.return_unstack;
      v[`MMF_BIT_DACC] = f.data_viol;
      // (RQ9) recorded only when executed
      v[`MMF_BIT_IACC] = f.instr_viol & f.instr_exec;
      // (RQ4) (RQ8) data violation validates address
      v[`MMF_BIT_AVALID] = f.data_viol;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] fset;
    logic [7:0] wmask;
    logic hit_st;
    logic hit_ad;
    logic hit_ct;
    logic alias_ns;
    logic bank_ns;
    logic alias_zero;
    logic size_ok;
    logic [31:0] rd;
    logic [7:0] clr_s;
    logic [7:0] clr_ns;
    logic [7:0] set_s;
    logic [7:0] set_ns;
    fset = 8'h00;
    wmask = 8'h00;
    rd = 32'h00000000;
    clr_s = 8'h00;
    clr_ns = 8'h00;
    set_s = 8'h00;
    set_ns = 8'h00;
    hit_st = 1'b0;
    hit_ad = 1'b0;
    hit_ct = 1'b0;
    alias_ns = 1'b0;
    bank_ns = 1'b0;
    alias_zero = 1'b0;
    size_ok = 1'b0;
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    nxt_st.bus_err = 1'b0;
    nxt_st.attr = mmf_attr_decode(attr_in);
    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    hit_st = mmf_hit(bus_in.addr, `MMF_STATUS_ADDR, `MMF_STATUS_NS_ADDR);
    hit_ad = mmf_hit(bus_in.addr, `MMF_ADDRESS_ADDR, `MMF_ADDRESS_NS_ADDR);
    hit_ct = mmf_hit(bus_in.addr, `MMF_CTRL_ADDR, `MMF_CTRL_NS_ADDR);
    alias_ns = bus_in.addr[17];
    // (RQ14) alias zero to nonsecure and debugger
    alias_zero = alias_ns & (~bus_in.secure | bus_in.debug);
    bank_ns = alias_ns | ~bus_in.secure;
    // (RQ13) narrow access only on status byte
    size_ok = (bus_in.size == MMF_SZ_WORD) || (hit_st && MAIN_EXT);
    // ----------------------------------------------------------------
    // fault flags, for the bank of the faulting state
    // ----------------------------------------------------------------
    fset = mmf_fault_flags(fault_in);
    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    if (bus_in.req) begin
      nxt_st.rvalid = 1'b1;
      // (RQ12) unprivileged access faults
      if (!(bus_in.priv || bus_in.debug) || !(hit_st || hit_ad || hit_ct) || !size_ok) begin
        nxt_st.bus_err = 1'b1;
      end else if (alias_zero) begin
        rd = 32'h00000000;
      end else if (!bus_in.wr) begin
        // (RQ10) reserved bits read zero
        if (hit_st) begin
          rd = {24'h000000, (bank_ns ? st_ff.status_ns : st_ff.status_s) & `MMF_STATUS_IMPL};
        end else if (hit_ad) begin
          // (RQ3) shared register unspecified under bus-fault valid
          rd = (SHARED_FAULT_ADDR && fault_in.bus_addr_valid) ? `MMF_ADDR_RST :
               (bank_ns ? st_ff.addr_ns : st_ff.addr_s);
        end else begin
          // (RQ20) bits 31:3 read zero
          rd = {29'h00000000, bank_ns ? st_ff.ctrl_ns : st_ff.ctrl_s};
        end
      end else if (hit_st) begin
        wmask = bus_in.wdata[7:0] & `MMF_STATUS_IMPL;
      end else if (hit_ad) begin
        // (RQ15) banked address write
        if (bank_ns) begin
          nxt_st.addr_ns = bus_in.wdata;
        end else begin
          nxt_st.addr_s = bus_in.wdata;
        end
      end else if (CTRL_WRITABLE) begin
        // (RQ21) banked control write
        if (bank_ns) begin
          nxt_st.ctrl_ns = bus_in.wdata[2:0];
        end else begin
          nxt_st.ctrl_s = bus_in.wdata[2:0];
        end
      end
    end
    nxt_st.rdata = rd;
    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    // (RQ25) clear by one, set wins
    if (bank_ns) begin
      clr_ns = wmask;
    end else begin
      clr_s = wmask;
    end
    // (RQ5) (RQ6) (RQ7) flags set in the faulting bank
    if (fault_in.secure) begin
      set_s = fset;
    end else begin
      set_ns = fset;
    end
    nxt_st.status_s = mmf_w1c(st_ff.status_s, clr_s, set_s);
    nxt_st.status_ns = mmf_w1c(st_ff.status_ns, clr_ns, set_ns);
    // ----------------------------------------------------------------
    // address capture
    // ----------------------------------------------------------------
    // (RQ1) address capture
    // (RQ2) (RQ4) valid flag set together with it
    if (fset[`MMF_BIT_AVALID]) begin
      if (fault_in.secure) begin
        nxt_st.addr_s = fault_in.addr;
      end else begin
        nxt_st.addr_ns = fault_in.addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // reset release and state
  // ----------------------------------------------------------------
  // two-flop release of the asynchronous reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_int_n = rst_sync_ff[1];

  // (RQ11) (RQ22) (RQ23) (RQ24) warm reset clears
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_ff.status_s <= `MMF_STATUS_RST;
      st_ff.status_ns <= `MMF_STATUS_RST;
      st_ff.addr_s <= `MMF_ADDR_RST;
      st_ff.addr_ns <= `MMF_ADDR_RST;
      st_ff.ctrl_s <= `MMF_CTRL_RST;
      st_ff.ctrl_ns <= `MMF_CTRL_RST;
      st_ff.rdata <= 32'h00000000;
      st_ff.rvalid <= 1'b0;
      st_ff.bus_err <= 1'b0;
      st_ff.attr <= '0;
    end else if (clk_en) begin
      st_ff.status_s <= nxt_st.status_s;
      st_ff.status_ns <= nxt_st.status_ns;
      st_ff.addr_s <= nxt_st.addr_s;
      st_ff.addr_ns <= nxt_st.addr_ns;
      st_ff.ctrl_s <= nxt_st.ctrl_s;
      st_ff.ctrl_ns <= nxt_st.ctrl_ns;
      st_ff.rdata <= nxt_st.rdata;
      st_ff.rvalid <= nxt_st.rvalid;
      st_ff.bus_err <= nxt_st.bus_err;
      st_ff.attr <= nxt_st.attr;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // (RQ2) valid flag qualifies address
  assign rdata = st_ff.rdata;
  assign rvalid = st_ff.rvalid;
  assign bus_err = st_ff.bus_err;
  // (RQ23) background bit passed out as stored, not ignored while bit 0 is clear
  assign ctrl_secure = st_ff.ctrl_s;
  assign ctrl_nonsecure = st_ff.ctrl_ns;
  assign status_secure = st_ff.status_s;
  assign status_nonsecure = st_ff.status_ns;
  assign attr_dec = st_ff.attr;

endmodule

// [dv/mmf_chk.sv]
// mmf_chk: port assertions of mmf_core
// assumes: bound to every mmf_core, one clock domain
`timescale 1ns/1ps
`include "mmf_params.svh"
module mmf_chk
  import mmf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire mmf_bus_s bus_in,
  input wire mmf_fault_s fault_in,
  input wire mmf_attr_s attr_in,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic bus_err,
  input wire logic [2:0] ctrl_secure,
  input wire logic [2:0] ctrl_nonsecure,
  input wire logic [7:0] status_secure,
  input wire logic [7:0] status_nonsecure,
  input wire mmf_attr_dec_s attr_dec
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic flt;
  assign flt = clk_en && fault_in.valid && fault_in.secure;
  // ----------------
  // assertions
  // ----------------
  AST_DACC: assert property (flt && fault_in.data_viol |=>
    status_secure[1] && status_secure[7]) else $error("data fault not flagged");
  AST_LSP: assert property (flt && fault_in.lazy_fp |=> status_secure[5])
    else $error("lazy fp fault not flagged");
  AST_STK: assert property (flt && fault_in.entry_stack |=> status_secure[4])
    else $error("stacking fault not flagged");
  AST_UNSTK: assert property (flt && fault_in.return_unstack |=> status_secure[3])
    else $error("unstacking fault not flagged");
  AST_IEXEC: assert property ($rose(status_secure[0]) |->
    $past(flt && fault_in.instr_viol && fault_in.instr_exec)) else $error("instr flag unexecuted");
  AST_RES0: assert property (!(status_secure[6] || status_secure[2]))
    else $error("reserved status bit set");
  AST_W1C: assert property ($fell(status_secure[1]) |-> $past(clk_en && bus_in.req &&
    bus_in.wr && bus_in.wdata[1] && bus_in.addr == `MMF_STATUS_ADDR)) else $error("flag lost");
  AST_UNPRIV: assert property (clk_en && bus_in.req && !bus_in.priv && !bus_in.debug |=>
    rvalid && bus_err) else $error("unprivileged access not refused");
  AST_DEV: assert property (clk_en && attr_in.outer == 4'h0 |=>
    attr_dec.outer_type == MMF_MEM_DEVICE && attr_dec.device_kind == $past(attr_in.inner[3:2]))
    else $error("device decode wrong");
  AST_NC: assert property (clk_en && attr_in.outer == 4'h4 |=>
    attr_dec.outer_type == MMF_MEM_NONCACHE) else $error("non-cacheable decode wrong");
  // ----------------
  // covers
  // ----------------
  COV_FLT: cover property (flt ##1 status_secure[7]);
  COV_ERR: cover property (rvalid && bus_err);
  COV_CLR: cover property ($fell(status_secure[7]));
endmodule
bind mmf_core mmf_chk i_mmf_chk (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
  .bus_in(bus_in), .fault_in(fault_in), .attr_in(attr_in), .rdata(rdata), .rvalid(rvalid),
  .bus_err(bus_err), .ctrl_secure(ctrl_secure), .ctrl_nonsecure(ctrl_nonsecure),
  .status_secure(status_secure), .status_nonsecure(status_nonsecure), .attr_dec(attr_dec));

// [dv/mmf_fault_src.sv]
// mmf_fault_src: core access path model giving one-cycle fault pulses
// assumes: go is a one-cycle command from the bench
`timescale 1ns/1ps
module mmf_fault_src
  import mmf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [31:0] fa,
  output mmf_fault_s fault_out
);
  mmf_fault_s nxt_fault;
  initial fault_out = '0;
  always @(posedge clk_sys) begin
    nxt_fault = '0;
    // idle address lines toggle, never hold
    nxt_fault.addr = ~fault_out.addr;
    if (go) begin
      nxt_fault.valid = 1'b1;
      nxt_fault.secure = 1'b1;
      nxt_fault.addr = fa;
      nxt_fault.data_viol = (kind == 3'h0);
      nxt_fault.lazy_fp = (kind == 3'h1);
      nxt_fault.entry_stack = (kind == 3'h2);
      nxt_fault.return_unstack = (kind == 3'h3);
      nxt_fault.instr_viol = (kind >= 3'h4);
      nxt_fault.instr_exec = (kind == 3'h5);
    end
    fault_out <= nxt_fault;
  end
endmodule

// [dv/test_memfault_status_and_attr.sv]
// test_memfault_status_and_attr: directed register, fault and decode tests
// assumes: mmf_core, mmf_fault_src and mmf_chk compiled before
`timescale 1ns/1ps
`include "mmf_params.svh"
module test_memfault_status_and_attr
  import mmf_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic go = 1'b0;
  logic e, rvalid, bus_err;
  logic [2:0] kind = 3'h0;
  logic [2:0] ctrl_secure, ctrl_nonsecure;
  logic [7:0] status_secure, status_nonsecure;
  logic [31:0] fa = 32'h0;
  logic [31:0] q, rdata;
  mmf_size_e sz = MMF_SZ_WORD;
  mmf_bus_s bus_in = '0;
  mmf_attr_s attr_in = '0;
  mmf_fault_s fault_in;
  mmf_attr_dec_s attr_dec;
  logic [7:0] fexp [6] = '{8'h82, 8'h20, 8'h10, 8'h08, 8'h00, 8'h01};
  logic [7:0] av [8] = '{8'h0C, 8'h44, 8'h33, 8'h77, 8'hBB, 8'hFF, 8'h30, 8'h40};
  logic [31:0] aexp [8] = '{32'h80000000, 32'h80000001, 32'h80000002, 32'h80000003,
    32'h80000004, 32'h80000005, 32'h2, 32'h1};
  logic [31:0] hexp [8] = '{32'h030, 32'h100, 32'h20F, 32'h30F, 32'h40F, 32'h50F, 32'h60C,
    32'h600};
  logic [31:0] hv;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  mmf_fault_src i_mmf_fault_src (.clk_sys(clk_sys), .go(go), .kind(kind), .fa(fa),
    .fault_out(fault_in));
  mmf_core i_mmf_core (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .bus_in(bus_in),
    .fault_in(fault_in), .attr_in(attr_in), .rdata(rdata), .rvalid(rvalid), .bus_err(bus_err),
    .ctrl_secure(ctrl_secure), .ctrl_nonsecure(ctrl_nonsecure), .status_secure(status_secure),
    .status_nonsecure(status_nonsecure), .attr_dec(attr_dec));
  // ----------------
  // tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic p,
    input logic s);
    @(posedge clk_sys);
    bus_in <= '{req: 1'b1, wr: w, addr: a, wdata: d, size: sz, priv: p, secure: s, debug: 1'b0};
    @(posedge clk_sys);
    bus_in.req <= 1'b0;
    #1;
    q = rdata;
    e = bus_err;
    chk({31'h0, rvalid}, 32'h1);
  endtask
  task automatic flt(input logic [2:0] k, input logic [31:0] a);
    @(posedge clk_sys);
    go <= 1'b1;
    kind <= k;
    fa <= a;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      $display("[FAIL] %0t run too long", $time);
      report_and_stop;
    end
  end
  // ----------------
  // tests
  // ----------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    acc(1'b0, `MMF_STATUS_ADDR, 32'h0, 1'b1, 1'b1);
    chk(q, 32'h0);
    acc(1'b0, `MMF_CTRL_ADDR, 32'h0, 1'b1, 1'b1);
    chk(q, 32'h0);
    $display("test reset done");
    flt(3'h0, 32'h2000_0A44);
    acc(1'b0, `MMF_ADDRESS_ADDR, 32'h0, 1'b1, 1'b1);
    chk(q, 32'h2000_0A44);
    acc(1'b1, `MMF_STATUS_ADDR, 32'h02, 1'b1, 1'b1);
    acc(1'b0, `MMF_STATUS_ADDR, 32'h0, 1'b1, 1'b1);
    chk(q, 32'h80);
    acc(1'b0, `MMF_STATUS_NS_ADDR, 32'h0, 1'b1, 1'b0);
    chk(q, 32'h0);
    chk({24'h0, status_nonsecure}, 32'h0);
    acc(1'b1, `MMF_STATUS_ADDR, 32'h80, 1'b1, 1'b1);
    for (int i = 0; i < 6; i++) begin
      flt(i[2:0], 32'h3000_0000 + i);
      acc(1'b0, `MMF_STATUS_ADDR, 32'h0, 1'b1, 1'b1);
      chk(q, {24'h0, fexp[i]});
      acc(1'b1, `MMF_STATUS_ADDR, 32'hFF, 1'b1, 1'b1);
      chk({24'h0, status_secure}, 32'h0);
    end
    sz = MMF_SZ_BYTE;
    flt(3'h0, 32'h3000_0010);
    acc(1'b1, `MMF_STATUS_ADDR, 32'h82, 1'b1, 1'b1);
    chk({31'h0, e}, 32'h0);
    chk({24'h0, status_secure}, 32'h0);
    sz = MMF_SZ_WORD;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    flt(3'h0, 32'h3000_0020);
    clk_en <= 1'b1;
    acc(1'b0, `MMF_STATUS_ADDR, 32'h0, 1'b1, 1'b1);
    chk(q, 32'h0);
    $display("test faults done");
    acc(1'b0, `MMF_STATUS_ADDR, 32'h0, 1'b0, 1'b1);
    chk({31'h0, e}, 32'h1);
    acc(1'b0, 32'hE000ED30, 32'h0, 1'b1, 1'b1);
    chk({31'h0, e}, 32'h1);
    sz = MMF_SZ_HALF;
    acc(1'b1, `MMF_CTRL_ADDR, 32'h1, 1'b1, 1'b1);
    chk({31'h0, e}, 32'h1);
    sz = MMF_SZ_WORD;
    acc(1'b1, `MMF_CTRL_ADDR, 32'hFFFFFFFF, 1'b1, 1'b1);
    acc(1'b0, `MMF_CTRL_ADDR, 32'h0, 1'b1, 1'b1);
    chk(q, 32'h7);
    chk({29'h0, ctrl_secure}, 32'h7);
    acc(1'b1, `MMF_CTRL_NS_ADDR, 32'h5, 1'b1, 1'b1);
    chk({29'h0, ctrl_nonsecure}, 32'h5);
    acc(1'b0, `MMF_CTRL_NS_ADDR, 32'h0, 1'b1, 1'b0);
    chk(q, 32'h0);
    $display("test access done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      attr_in <= av[i];
      repeat (2) @(posedge clk_sys);
      #1;
      chk({attr_dec.legal, 28'h0, attr_dec.outer_type}, aexp[i]);
      hv = {21'h0, attr_dec.inner_type, 2'h0, attr_dec.device_kind, attr_dec.outer_ra,
        attr_dec.outer_wa, attr_dec.inner_ra, attr_dec.inner_wa};
      chk(hv, hexp[i]);
    end
    $display("test attributes done");
    report_and_stop;
  end
endmodule
